// ==== rtl/prs_pkg.sv ====
package prs_pkg;
   // Clock and timing
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned SETUP_OPEN_S = 2;
   localparam int unsigned SETUP_LOW_S = 4;
   localparam int unsigned SETUP_HIGH_S = 6;
   localparam int unsigned RESET_SHORT_MS = 140;
   localparam int unsigned RESET_LONG_MS = 240;
   localparam int unsigned SETUP_OPEN_CYC = SETUP_OPEN_S * CLK_HZ;
   localparam int unsigned SETUP_LOW_CYC = SETUP_LOW_S * CLK_HZ;
   localparam int unsigned SETUP_HIGH_CYC = SETUP_HIGH_S * CLK_HZ;
   localparam int unsigned RESET_SHORT_CYC = (RESET_SHORT_MS * (CLK_HZ / 1000));
   localparam int unsigned RESET_LONG_CYC = (RESET_LONG_MS * (CLK_HZ / 1000));
   localparam int unsigned CNT_W = 26;
   localparam int unsigned SYNC_W = 5;

   // Synchroniser bit positions
   localparam int unsigned IDX_UV = 4;
   localparam int unsigned IDX_REQ_A = 3;
   localparam int unsigned IDX_REQ_B = 2;
   localparam int unsigned IDX_SEL_HIGH = 1;
   localparam int unsigned IDX_SEL_LOW = 0;

   // Three-state select encoding
   typedef enum logic [1:0] {
      PRS_SEL_OPEN = 2'h0,
      PRS_SEL_LOW = 2'h1,
      PRS_SEL_HIGH = 2'h2
   } prs_sel_t;

   // Supervisor states
   typedef enum logic [1:0] {
      PRS_IDLE = 2'h0,
      PRS_HOLD = 2'h1,
      PRS_ASSERT = 2'h2,
      PRS_WAIT = 2'h3
   } prs_state_t;
endpackage

// ==== rtl/prs_supervisor.sv ====
`timescale 1ns/1ps
// How it works
// (RULE1) The high reset output rises on undervoltage or when both buttons are held for the setup delay.
// (RULE2) The high reset output stays up for the reset timeout after supply recovery or setup expiry.
// (RULE3) The low reset output falls under the same conditions that raise the high output.
// (RULE4) The low reset output stays low for the reset timeout after recovery or setup expiry.
// (RULE5) Holding both buttons for the setup delay gives exactly one reset of the timeout length.
// (RULE6) The setup delay is 2 s with select open, 4 s when tied low and 6 s when tied high.
// (RULE7) Undervoltage asserts both outputs at once with no qualifying delay.
// (RULE8) The reset timeout is a build option of 140 ms or 240 ms minimum.
// (RULE9) Releasing either button before the setup delay ends clears the count with no reset.
module prs_supervisor
   import prs_pkg::*;
#(
   parameter bit LONG_TIMEOUT = 1'b0,
   parameter int unsigned SETUP_OPEN_CYCLES = SETUP_OPEN_CYC,
   parameter int unsigned SETUP_LOW_CYCLES = SETUP_LOW_CYC,
   parameter int unsigned SETUP_HIGH_CYCLES = SETUP_HIGH_CYC,
   parameter int unsigned RESET_CYCLES = LONG_TIMEOUT ? RESET_LONG_CYC : RESET_SHORT_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   // Supply monitor and buttons
   input wire logic supply_low,
   input wire logic manual_req_a_n,
   input wire logic manual_req_b_n,
   // Three-state select: tied high, tied low, open
   input wire logic hold_sel_high,
   input wire logic hold_sel_low,
   // Reset outputs; low output is open drain
   output logic reset_out_high,
   output logic reset_out_low_o,
   output logic reset_out_low_oe_n
);
   typedef struct packed {
      prs_state_t state;
      logic [CNT_W-1:0] cnt;
      logic rst_high;
   } prs_state_rec_t;

   prs_state_rec_t st;
   prs_state_rec_t next_st;
   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] sync_in;
   logic uv;
   logic both_held;
   prs_sel_t sel;
   logic [CNT_W-1:0] setup_cycles;

   // Refuse counts that the counter cannot hold
   if (SETUP_HIGH_CYCLES >= (64'd1 << CNT_W) || SETUP_LOW_CYCLES >= (64'd1 << CNT_W)
       || SETUP_OPEN_CYCLES >= (64'd1 << CNT_W) || RESET_CYCLES >= (64'd1 << CNT_W)
       || SETUP_OPEN_CYCLES < 1 || SETUP_LOW_CYCLES < 1 || SETUP_HIGH_CYCLES < 1
       || RESET_CYCLES < 1) begin : g_bad_counts
      $error("prs_supervisor counts out of range");
   end

   // Pin inputs, two flip-flops each
   assign raw_in = {supply_low, manual_req_a_n, manual_req_b_n, hold_sel_high, hold_sel_low};

   prs_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .clk_en(clk_en),
      .din(raw_in),
      .dout(sync_in)
   );

   assign uv = sync_in[IDX_UV];
   assign both_held = !sync_in[IDX_REQ_A] && !sync_in[IDX_REQ_B];

   // Setup select decode, tied high wins
   always_comb begin
      if (sync_in[IDX_SEL_HIGH]) begin
         sel = PRS_SEL_HIGH;
      end else if (sync_in[IDX_SEL_LOW]) begin
         sel = PRS_SEL_LOW;
      end else begin
         sel = PRS_SEL_OPEN;
      end
      case (sel) // [RULE6]
         PRS_SEL_LOW: setup_cycles = CNT_W'(SETUP_LOW_CYCLES);
         PRS_SEL_HIGH: setup_cycles = CNT_W'(SETUP_HIGH_CYCLES);
         default: setup_cycles = CNT_W'(SETUP_OPEN_CYCLES);
      endcase
   end

   // Supervisor state machine, frozen while the enable is low
   always_comb begin
      next_st = st;
      if (clk_en) begin
         case (st.state)
            PRS_IDLE: begin
               next_st.cnt = '0;
               next_st.rst_high = 1'b0;
               if (uv) begin
                  next_st.state = PRS_ASSERT; // [RULE7]
                  next_st.rst_high = 1'b1; // [RULE1] [RULE3]
               end else if (both_held) begin
                  next_st.state = PRS_HOLD;
                  next_st.cnt = CNT_W'(1);
               end
            end
            PRS_HOLD: begin
               if (uv) begin
                  next_st.state = PRS_ASSERT; // [RULE7]
                  next_st.rst_high = 1'b1;
                  next_st.cnt = '0;
               end else if (!both_held) begin
                  next_st.state = PRS_IDLE; // [RULE9]
                  next_st.cnt = '0;
               end else if (st.cnt >= setup_cycles) begin
                  next_st.state = PRS_ASSERT; // [RULE1] [RULE3] [RULE5]
                  next_st.rst_high = 1'b1;
                  next_st.cnt = '0;
               end else begin
                  next_st.cnt = st.cnt + CNT_W'(1);
               end
            end
            PRS_ASSERT: begin
               next_st.rst_high = 1'b1;
               if (uv) begin
                  next_st.cnt = '0;
               end else if (st.cnt >= CNT_W'(RESET_CYCLES - 1)) begin
                  next_st.rst_high = 1'b0; // [RULE2] [RULE4] [RULE8]
                  next_st.state = PRS_WAIT;
                  next_st.cnt = '0;
               end else begin
                  next_st.cnt = st.cnt + CNT_W'(1);
               end
            end
            PRS_WAIT: begin
               next_st.cnt = '0;
               if (uv) begin
                  next_st.state = PRS_ASSERT;
                  next_st.rst_high = 1'b1;
               end else if (!both_held) begin
                  next_st.state = PRS_IDLE; // [RULE5]
               end
            end
            default: begin
               next_st.state = PRS_IDLE;
               next_st.cnt = '0;
               next_st.rst_high = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st <= '{state: PRS_IDLE, cnt: '0, rst_high: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // Registered reset outputs; the low one only pulls down
   assign reset_out_high = st.rst_high;
   assign reset_out_low_o = 1'b0;
   assign reset_out_low_oe_n = !st.rst_high; // [RULE3] [RULE4]

   // Checks on the supervisor's own behaviour
   a_uv_asserts: assert property (@(posedge clk_sys) disable iff (rst) // [RULE7]
      clk_en && uv |=> reset_out_high)
      else $error("undervoltage did not assert reset");
   a_outputs_agree: assert property (@(posedge clk_sys) disable iff (rst) // [RULE3]
      reset_out_high == !reset_out_low_oe_n)
      else $error("reset outputs disagree");
   a_release_cancel: assert property (@(posedge clk_sys) disable iff (rst) // [RULE9]
      clk_en && st.state == PRS_HOLD && !both_held && !uv |=> !reset_out_high && st.cnt == '0)
      else $error("button release did not cancel");
   a_rise_cause: assert property (@(posedge clk_sys) disable iff (rst) // [RULE1]
      $rose(reset_out_high) |-> $past(uv) || $past(st.state) == PRS_HOLD)
      else $error("reset rose without cause");
   a_hold_min: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
      $rose(reset_out_high) |=> reset_out_high [*8])
      else $error("reset too short");
   a_fall_count: assert property (@(posedge clk_sys) disable iff (rst) // [RULE4]
      $fell(reset_out_high) |-> $past(st.cnt) == CNT_W'(RESET_CYCLES - 1) && !$past(uv))
      else $error("reset released early");
   a_one_shot: assert property (@(posedge clk_sys) disable iff (rst) // [RULE5]
      st.state == PRS_WAIT && !uv |-> !reset_out_high)
      else $error("second reset while buttons held");
   a_wait_stays: assert property (@(posedge clk_sys) disable iff (rst) // [RULE5]
      clk_en && st.state == PRS_WAIT && both_held && !uv |=> st.state == PRS_WAIT)
      else $error("hold restarted without release");
   a_setup_sel: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
      sync_in[IDX_SEL_HIGH] |-> setup_cycles == CNT_W'(SETUP_HIGH_CYCLES))
      else $error("setup select wrong");
   a_setup_low: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
      !sync_in[IDX_SEL_HIGH] && sync_in[IDX_SEL_LOW]
      |-> setup_cycles == CNT_W'(SETUP_LOW_CYCLES))
      else $error("setup select low wrong");
   a_setup_open: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
      !sync_in[IDX_SEL_HIGH] && !sync_in[IDX_SEL_LOW]
      |-> setup_cycles == CNT_W'(SETUP_OPEN_CYCLES))
      else $error("setup select open wrong");
   a_hold_early: assert property (@(posedge clk_sys) disable iff (rst) // [RULE1]
      clk_en && st.state == PRS_HOLD && both_held && !uv && st.cnt < setup_cycles
      |=> st.state == PRS_HOLD && st.cnt == $past(st.cnt) + CNT_W'(1))
      else $error("hold ended before setup delay");
   a_uv_in_hold: assert property (@(posedge clk_sys) disable iff (rst) // [RULE7]
      clk_en && uv && st.state == PRS_HOLD |=> st.state == PRS_ASSERT && reset_out_high)
      else $error("undervoltage ignored during hold");
   a_uv_restart: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
      clk_en && uv && st.state == PRS_ASSERT |=> reset_out_high && st.cnt == '0)
      else $error("timeout ran during undervoltage");
   a_enable_freeze: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
      !clk_en |=> st == $past(st) && sync_in == $past(sync_in))
      else $error("state moved while enable low");
   c_uv_reset: cover property (@(posedge clk_sys) disable iff (rst) $rose(uv) ##1 reset_out_high);
   c_manual: cover property (@(posedge clk_sys) disable iff (rst)
      st.state == PRS_HOLD ##1 st.state == PRS_ASSERT);
   c_cancel: cover property (@(posedge clk_sys) disable iff (rst)
      st.state == PRS_HOLD ##1 st.state == PRS_IDLE);
   c_release: cover property (@(posedge clk_sys) disable iff (rst) $fell(reset_out_high));
   c_freeze: cover property (@(posedge clk_sys) disable iff (rst) !clk_en && reset_out_high);
endmodule // prs_supervisor

// ==== rtl/prs_sync.sv ====
`timescale 1ns/1ps
module prs_sync
   import prs_pkg::*;
#(
   parameter int unsigned WIDTH = SYNC_W
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   // Data
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } prs_sync_state_t;

   prs_sync_state_t st;
   prs_sync_state_t next_st;

   if (WIDTH < 1) begin : g_bad_width
      $error("prs_sync width must be at least 1");
   end

   always_comb begin
      next_st = st;
      if (clk_en) begin
         next_st.s1 = din;
         next_st.s2 = st.s1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign dout = st.s2;
endmodule // prs_sync

// ==== test/prs_btn_model.sv ====
`timescale 1ns/1ps
module prs_btn_model (
   // Bench commands
   input wire logic press_a,
   input wire logic press_b,
   input wire logic undervolt,
   // Pins toward the supervisor
   output logic manual_req_a_n,
   output logic manual_req_b_n,
   output logic supply_low
);
   // Released buttons float to the pull-up level
   assign manual_req_a_n = press_a ? 1'h0 : 1'h1;
   assign manual_req_b_n = press_b ? 1'h0 : 1'h1;
   assign supply_low = undervolt;
endmodule // prs_btn_model

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
   import prs_pkg::*;
   logic clk_sys, rst, clk_en, press_a, press_b, uv, sel_high, sel_low;
   logic mr_a_n, mr_b_n, sup_low, reset_out_high, reset_out_low_o, reset_out_low_oe_n;
   int error_cnt = 0;
   int tests_run = 0;
   int c;

   prs_btn_model model (.press_a(press_a), .press_b(press_b), .undervolt(uv),
      .manual_req_a_n(mr_a_n), .manual_req_b_n(mr_b_n), .supply_low(sup_low));
   prs_supervisor #(.SETUP_OPEN_CYCLES(20), .SETUP_LOW_CYCLES(40),
      .SETUP_HIGH_CYCLES(60), .RESET_CYCLES(10)) dut (.clk_sys(clk_sys), .rst(rst),
      .clk_en(clk_en), .supply_low(sup_low), .manual_req_a_n(mr_a_n),
      .manual_req_b_n(mr_b_n), .hold_sel_high(sel_high), .hold_sel_low(sel_low),
      .reset_out_high(reset_out_high), .reset_out_low_o(reset_out_low_o),
      .reset_out_low_oe_n(reset_out_low_oe_n));

   initial begin
      clk_sys = 1'h0;
      forever #50 clk_sys = ~clk_sys;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task end_of_test;
      $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task edges(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // Edges until the high reset reaches lvl, bounded
   task count_until(input logic lvl, output int n);
      n = 0;
      while (reset_out_high !== lvl && n < 300) begin
         edges(1);
         n++;
      end
   endtask

   // Edges on which the high reset shows, over a window
   task count_high(input int n, output int hits);
      hits = 0;
      repeat (n) begin
         edges(1);
         if (reset_out_high !== 1'h0) hits++;
      end
   endtask

   task test_uv;
      uv = 1'h1;
      edges(2);
      check(reset_out_high, 1'h0, "uv too early");
      edges(1);
      check(reset_out_high, 1'h1, "uv high late");
      check(reset_out_low_oe_n, 1'h0, "uv low not driven");
      check(reset_out_low_o, 1'h0, "low data");
      edges(30);
      check(reset_out_high, 1'h1, "uv dropped while low");
      uv = 1'h0;
      count_until(1'h0, c);
      check(c >= 10 && c <= 14, 1'h1, "uv timeout length");
      check(reset_out_low_oe_n, 1'h1, "low not released");
      $display("test_uv done");
   endtask

   task test_manual(input logic sh, input logic sl, input int s);
      sel_high = sh;
      sel_low = sl;
      edges(3);
      press_a = 1'h1;
      press_b = 1'h1;
      count_until(1'h1, c);
      check(c >= s + 1 && c <= s + 5, 1'h1, "setup delay");
      check(reset_out_low_oe_n, 1'h0, "manual low");
      count_until(1'h0, c);
      check(c >= 10 && c <= 14, 1'h1, "manual reset length");
      count_high(s + 20, c);
      check(c, 0, "second reset");
      press_a = 1'h0;
      press_b = 1'h0;
      edges(5);
      $display("test_manual done for %0d", s);
   endtask

   task test_cancel;
      sel_high = 1'h0;
      sel_low = 1'h0;
      press_a = 1'h1;
      press_b = 1'h1;
      edges(15);
      press_b = 1'h0;
      edges(5);
      press_b = 1'h1;
      count_high(15, c);
      check(c, 0, "count not cleared");
      press_a = 1'h0;
      count_high(40, c);
      check(c, 0, "reset after release");
      press_b = 1'h0;
      $display("test_cancel done");
   endtask

   task test_mid_reset;
      uv = 1'h1;
      edges(3);
      check(reset_out_high, 1'h1, "uv before reset");
      rst = 1'h1;
      edges(1);
      check(reset_out_high, 1'h0, "async reset high");
      check(reset_out_low_oe_n, 1'h1, "async reset low");
      rst = 1'h0;
      edges(2);
      check(reset_out_high, 1'h0, "uv seen too early");
      edges(1);
      check(reset_out_high, 1'h1, "uv after reset");
      uv = 1'h0;
      count_until(1'h0, c);
      check(c >= 10 && c <= 14, 1'h1, "timeout after reset");
      $display("test_mid_reset done");
   endtask

   task test_override;
      sel_high = 1'h0;
      sel_low = 1'h0;
      press_a = 1'h1;
      press_b = 1'h1;
      edges(10);
      uv = 1'h1;
      edges(3);
      check(reset_out_high, 1'h1, "uv in hold late");
      uv = 1'h0;
      clk_en = 1'h0;
      edges(40);
      check(reset_out_high, 1'h1, "freeze lost");
      clk_en = 1'h1;
      count_until(1'h0, c);
      check(c >= 10 && c <= 14, 1'h1, "timeout after freeze");
      count_high(30, c);
      check(c, 0, "reset again while held");
      press_a = 1'h0;
      press_b = 1'h0;
      edges(5);
      $display("test_override done");
   endtask

   initial begin
      rst = 1'h1;
      press_a = 1'h0;
      press_b = 1'h0;
      uv = 1'h0;
      sel_high = 1'h0;
      sel_low = 1'h0;
      clk_en = 1'h1;
      edges(20);
      rst = 1'h0;
      edges(2);
      check(reset_out_high, 1'h0, "reset value high");
      check(reset_out_low_oe_n, 1'h1, "reset value low");
      test_uv();
      test_mid_reset();
      test_manual(1'h0, 1'h0, 20);
      test_manual(1'h0, 1'h1, 40);
      test_manual(1'h1, 1'h0, 60);
      test_manual(1'h1, 1'h1, 60);
      test_override();
      test_cancel();
      end_of_test();
   end

   initial begin
      edges(3000);
      error_cnt++;
      $display("mismatch at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule // tb
